// ===== include/bridge_cfg_pkg.sv
// Constants and types shared by the bridge configuration header logic
package bridge_cfg_pkg;
    // Configuration access port widths
    localparam int CFG_DW_W = 6;   // Dword index within 256-byte space
    localparam int CFG_BE_W = 4;   // Byte enables, one per lane
    localparam int CFG_D_W = 32;   // Configuration data width
    localparam int BUS_W = 8;      // Bus number width

    // Byte offsets of the registers in configuration space
    localparam logic [7:0] OFS_CLASS_CODE = 8'h09;
    localparam logic [7:0] OFS_CACHE_LINE = 8'h0c;
    localparam logic [7:0] OFS_PRI_LAT = 8'h0d;
    localparam logic [7:0] OFS_HDR_TYPE = 8'h0e;
    localparam logic [7:0] OFS_SELF_TEST = 8'h0f;
    localparam logic [7:0] OFS_BASE_ADDR0 = 8'h10;
    localparam logic [7:0] OFS_BASE_ADDR1 = 8'h14;
    localparam logic [7:0] OFS_PRI_BUS = 8'h18;
    localparam logic [7:0] OFS_SEC_BUS = 8'h19;
    localparam logic [7:0] OFS_SUB_BUS = 8'h1a;
    localparam logic [7:0] OFS_DECODE_CTL = 8'h57;

    // Field positions and reset values
    localparam int DECODE_SUBTR_BIT = 0;  // Bit 0 of decode control
    localparam logic [15:0] CLASS_BASE_SUB = 16'h0604;
    localparam logic [23:0] CLASS_RESET = 24'h060401;
    localparam logic [7:0] HDR_TYPE_VAL = 8'h01;
    localparam logic [7:0] SELF_TEST_VAL = 8'h00;
    localparam logic [31:0] BASE_ADDR_VAL = 32'h0000_0000;
    localparam logic [7:0] CACHE_LINE_RESET = 8'h00;
    localparam logic [7:0] PRI_LAT_RESET = 8'h00;
    localparam logic [7:0] BUS_NUM_RESET = 8'h00;
    localparam logic DECODE_RESET = 1'b1;  // Subtractive after reset
    localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;

    // Outcome of a primary type 1 configuration cycle
    typedef enum logic [1:0] {
        FWD_NONE = 2'b00,   // Not claimed
        FWD_TYPE0 = 2'b01,  // Converted to type 0 on secondary
        FWD_TYPE1 = 2'b10   // Passed on unchanged as type 1
    } fwd_kind_t;

    // True when an access hits the byte at the given offset
    function automatic logic lane_hit(input logic [5:0] dw,
                                      input logic [3:0] be,
                                      input logic [7:0] ofs);
        lane_hit = (dw == ofs[7:2]) && be[ofs[1:0]];
    endfunction

    // Pick the byte lane of a data word that holds the given offset
    function automatic logic [7:0] lane_byte(input logic [31:0] data,
                                             input logic [7:0] ofs);
        lane_byte = data[{ofs[1:0], 3'b000} +: 8];
    endfunction
endpackage

// ===== core/primary_latency_counter.sv
// Primary latency timer count for bridge-initiated primary transactions
`timescale 1ns/100ps
module primary_latency_counter #(
    parameter int CNT_W = 8  // Width of timer value and count
) (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_frame_start,     // Bridge asserts frame as master
    input wire logic i_txn_active,      // Own primary transaction live
    input wire logic [CNT_W-1:0] i_limit, // Programmed timer value
    output logic o_expired               // Timer ran out, level
);
    import bridge_cfg_pkg::*;

    logic [CNT_W-1:0] count;  // Clocks since frame was asserted
    logic running;            // Count is live for this transaction

    // Count from zero at frame assertion, stop once limit is reached
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            count <= '0;
            running <= 1'b0;
        end else if (i_frame_start) begin
            count <= '0;
            running <= 1'b1;
        end else if (!i_txn_active) begin
            running <= 1'b0;  // Transaction ended, nothing to time
        end else if (running && count != i_limit) begin
            count <= count + 1'b1;
        end
    end

    // Expiry flag; the master drops frame when it sees it
    // Held until the transaction ends so the master cannot miss it
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_expired <= 1'b0;
        end else if (i_frame_start || !i_txn_active) begin
            o_expired <= 1'b0;
        end else if (running && count == i_limit) begin
            o_expired <= 1'b1;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // Fresh start with limit two, then three live cycles
    sequence s_run_two;
        i_frame_start && i_limit == 8'h02 ##1 i_txn_active[*3];
    endsequence

    a_lat_fresh: assert property (i_frame_start |=> !o_expired)
        else $error("latency flag set right after frame start");
    a_lat_expiry: assert property (s_run_two |=> o_expired)
        else $error("latency timer did not expire on time");
    a_lat_early: assert property (
        i_frame_start && i_limit == 8'h02 ##1 i_txn_active
        |=> !o_expired)
        else $error("latency timer expired too early");
endmodule

// ===== core/bridge_config_header_regs.sv
// Configuration header registers 09h..1Ah of the bridge
//
// How it works
// - Class code reads 0604h plus interface byte
// - Class bit 0 mirrors decode control bit
// - Decode control bit resets to subtractive
// - Writing zero selects positive primary decode
// - Cache line size register, read/write, reset 00h
// - Latency timer counts from zero at frame
// - Expired timer ends transaction at frame release
// - Header type always reads 01h
// - Self-test register reads 00h, no self-test
// - Base address 0 reads zero, read-only
// - Base address 1 reads zero, read-only
// - Primary bus number register, read/write
// - Secondary bus cycles become type 0
// - Subordinate bus number register, read/write
// - Deeper subordinate cycles stay type 1
`timescale 1ns/100ps
module bridge_config_header_regs (
    input wire logic i_mclk,
    input wire logic i_rst,
    // Configuration cycle access from the primary bus
    input wire logic i_cfg_wr,  // Write request, one cycle
    input wire logic i_cfg_rd,  // Read request, one cycle
    input wire logic [bridge_cfg_pkg::CFG_DW_W-1:0] i_cfg_dw,
    input wire logic [bridge_cfg_pkg::CFG_BE_W-1:0] i_cfg_be,
    input wire logic [bridge_cfg_pkg::CFG_D_W-1:0] i_cfg_wdata,
    output logic [bridge_cfg_pkg::CFG_D_W-1:0] o_cfg_rdata,
    output logic o_cfg_ack,  // Access completed, one cycle
    // Primary master side of the latency timer
    input wire logic i_frame_start,  // Bridge asserts frame
    input wire logic i_txn_active,   // Own primary transaction live
    output logic o_lat_expired,      // Drop frame when set
    // Primary type 1 configuration cycle decode
    input wire logic i_t1_valid,     // Type 1 cycle seen, one cycle
    input wire logic [bridge_cfg_pkg::BUS_W-1:0] i_t1_bus,
    output bridge_cfg_pkg::fwd_kind_t o_fwd_kind,
    output logic o_fwd_done,         // Decision ready, one cycle
    // Settings used by the rest of the bridge
    output logic o_subtractive,      // Primary subtractive decode
    output logic [7:0] o_cache_line_size,
    output logic [bridge_cfg_pkg::BUS_W-1:0] o_pri_bus,
    output logic [bridge_cfg_pkg::BUS_W-1:0] o_sec_bus,
    output logic [bridge_cfg_pkg::BUS_W-1:0] o_sub_bus
);
    import bridge_cfg_pkg::*;

    logic [7:0] pri_lat;     // Primary latency timer value
    logic decode_subtr;      // Decode control bit 0
    logic [23:0] class_code; // Class code as read back
    logic [31:0] next_rdata; // Read data for the addressed dword
    logic wr_cls;            // Write hits cache line size
    logic wr_lat;            // Write hits latency timer
    logic wr_pri;            // Write hits primary bus number
    logic wr_sec;            // Write hits secondary bus number
    logic wr_sub;            // Write hits subordinate bus number
    logic wr_dec;            // Write hits decode control

    // Lane decode of writes; read-only lanes have no decode at all
    always_comb begin
        wr_cls = i_cfg_wr && lane_hit(i_cfg_dw, i_cfg_be, OFS_CACHE_LINE);
        wr_lat = i_cfg_wr && lane_hit(i_cfg_dw, i_cfg_be, OFS_PRI_LAT);
        wr_pri = i_cfg_wr && lane_hit(i_cfg_dw, i_cfg_be, OFS_PRI_BUS);
        wr_sec = i_cfg_wr && lane_hit(i_cfg_dw, i_cfg_be, OFS_SEC_BUS);
        wr_sub = i_cfg_wr && lane_hit(i_cfg_dw, i_cfg_be, OFS_SUB_BUS);
        wr_dec = i_cfg_wr &&
            lane_hit(i_cfg_dw, i_cfg_be, OFS_DECODE_CTL);
    end

    // Class code: fixed upper bytes, bit 0 follows decode control
    // No write path exists, so the alias cannot drift from its source
    always_comb begin
        class_code = {CLASS_RESET[23:1], decode_subtr};
    end

    // Decode control bit: subtractive after reset
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            decode_subtr <= DECODE_RESET;
        end else if (wr_dec) begin
            // Zero here switches to positive decode
            decode_subtr <= i_cfg_wdata[24 + DECODE_SUBTR_BIT];
        end
    end

    // Primary decode mode seen by the target logic
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_subtractive <= DECODE_RESET;
        end else if (wr_dec) begin
            o_subtractive <= i_cfg_wdata[24 + DECODE_SUBTR_BIT];
        end
    end

    // Cache line size for read line and read multiple
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_cache_line_size <= CACHE_LINE_RESET;
        end else if (wr_cls) begin
            o_cache_line_size <= lane_byte(i_cfg_wdata,
                OFS_CACHE_LINE);
        end
    end

    // Primary latency timer value
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            pri_lat <= PRI_LAT_RESET;
        end else if (wr_lat) begin
            pri_lat <= lane_byte(i_cfg_wdata, OFS_PRI_LAT);
        end
    end

    // Bus numbers; each lane is written on its own byte enable
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_pri_bus <= BUS_NUM_RESET;
            o_sec_bus <= BUS_NUM_RESET;
            o_sub_bus <= BUS_NUM_RESET;
        end else begin
            if (wr_pri) begin
                o_pri_bus <= lane_byte(i_cfg_wdata, OFS_PRI_BUS);
            end
            if (wr_sec) begin
                o_sec_bus <= lane_byte(i_cfg_wdata, OFS_SEC_BUS);
            end
            if (wr_sub) begin
                o_sub_bus <= lane_byte(i_cfg_wdata, OFS_SUB_BUS);
            end
        end
    end

    // Read mux; the whole dword returns, lanes are picked by the master
    always_comb begin
        next_rdata = UNMAPPED_VAL;  // Unmapped dwords read zero
        if (i_cfg_dw == OFS_CLASS_CODE[7:2]) begin
            // Revision byte lies outside this block and reads zero
            next_rdata = {class_code, 8'h00};
        end else if (i_cfg_dw == OFS_CACHE_LINE[7:2]) begin
            next_rdata = {SELF_TEST_VAL, HDR_TYPE_VAL, pri_lat,
                o_cache_line_size};
        end else if (i_cfg_dw == OFS_BASE_ADDR0[7:2]) begin
            next_rdata = BASE_ADDR_VAL;
        end else if (i_cfg_dw == OFS_BASE_ADDR1[7:2]) begin
            next_rdata = BASE_ADDR_VAL;
        end else if (i_cfg_dw == OFS_PRI_BUS[7:2]) begin
            // Secondary latency byte belongs elsewhere, reads zero
            next_rdata = {8'h00, o_sub_bus, o_sec_bus, o_pri_bus};
        end else if (i_cfg_dw == OFS_DECODE_CTL[7:2]) begin
            next_rdata = {7'h00, decode_subtr, 24'h00_0000};
        end
    end

    // Answer every access one cycle later, writes included
    // Read-only lanes take writes silently and still acknowledge
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_cfg_ack <= 1'b0;
            o_cfg_rdata <= UNMAPPED_VAL;
        end else begin
            o_cfg_ack <= i_cfg_wr || i_cfg_rd;
            if (i_cfg_rd) begin
                o_cfg_rdata <= next_rdata;
            end
        end
    end

    // Type 1 forwarding decision against the bus number window
    // Equal secondary and subordinate leaves a one-bus window
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            o_fwd_kind <= FWD_NONE;
            o_fwd_done <= 1'b0;
        end else begin
            o_fwd_done <= i_t1_valid;
            if (i_t1_valid) begin
                if (i_t1_bus == o_sec_bus) begin
                    o_fwd_kind <= FWD_TYPE0;
                end else if (i_t1_bus > o_sec_bus &&
                             i_t1_bus <= o_sub_bus) begin
                    o_fwd_kind <= FWD_TYPE1;
                end else begin
                    o_fwd_kind <= FWD_NONE;
                end
            end
        end
    end

    // Latency timer for transactions the bridge starts on primary
    primary_latency_counter #(
        .CNT_W(8)
    ) u_lat (
        .i_mclk(i_mclk),
        .i_rst(i_rst),
        .i_frame_start(i_frame_start),
        .i_txn_active(i_txn_active),
        .i_limit(pri_lat),
        .o_expired(o_lat_expired)
    );

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    // A read of a dword, answered the cycle after
    sequence s_rd(logic [5:0] dw);
        i_cfg_rd && i_cfg_dw == dw;
    endsequence

    a_class_fixed: assert property (
        s_rd(6'h02) |=> o_cfg_ack && o_cfg_rdata[31:16] == 16'h0604)
        else $error("class code upper bytes wrong");
    a_class_alias: assert property (
        s_rd(6'h02) |=> o_cfg_rdata[8] == $past(o_subtractive))
        else $error("class code bit 0 not aliased");
    a_decode_reset: assert property (
        disable iff (1'b0) $past(i_rst) && !i_rst |-> o_subtractive)
        else $error("decode mode not subtractive at reset");
    a_decode_write: assert property (
        wr_dec && !i_cfg_wdata[24] ##1 s_rd(6'h02)
        |=> !o_subtractive && !o_cfg_rdata[8])
        else $error("zero write did not give positive decode");
    a_cls_write: assert property (
        wr_cls |=> o_cache_line_size == $past(i_cfg_wdata[7:0]))
        else $error("cache line size not written");
    a_hdr_fixed: assert property (
        i_cfg_wr ##1 s_rd(6'h03) |=> o_cfg_rdata[31:16] == 16'h0001)
        else $error("header or self-test byte wrong");
    a_self_test_zero: assert property (
        s_rd(6'h03) |=> o_cfg_rdata[31:24] == 8'h00)
        else $error("self-test byte not zero");
    a_bar0_zero: assert property (
        i_cfg_wr ##1 s_rd(6'h04) |=> o_cfg_rdata == 32'h0)
        else $error("base address 0 not zero");
    a_bar1_zero: assert property (
        s_rd(6'h05) |=> o_cfg_rdata == 32'h0)
        else $error("base address 1 not zero");
    a_pri_write: assert property (
        wr_pri |=> o_pri_bus == $past(i_cfg_wdata[7:0]))
        else $error("primary bus number not written");
    a_sub_write: assert property (
        wr_sub |=> o_sub_bus == $past(i_cfg_wdata[23:16]))
        else $error("subordinate bus number not written");
    a_fwd_type0: assert property (
        i_t1_valid && i_t1_bus == o_sec_bus
        |=> o_fwd_done && o_fwd_kind == FWD_TYPE0)
        else $error("secondary bus cycle not type 0");
    a_fwd_type1: assert property (
        i_t1_valid && i_t1_bus > o_sec_bus && i_t1_bus <= o_sub_bus
        |=> o_fwd_kind == FWD_TYPE1)
        else $error("subordinate cycle not kept type 1");
    // The secondary bus itself always wins, even with an empty window
    a_fwd_outside: assert property (
        i_t1_valid && i_t1_bus != o_sec_bus &&
        (i_t1_bus < o_sec_bus || i_t1_bus > o_sub_bus)
        |=> o_fwd_kind == FWD_NONE)
        else $error("cycle outside window was claimed");
    a_ro_ack: assert property (
        i_cfg_wr && i_cfg_dw == 6'h02
        |=> o_cfg_ack && $stable(o_subtractive))
        else $error("read-only write not completed cleanly");

    // Secondary bus number lands on the edge after the write
    a_sec_write: assert property (
        wr_sec |=> o_sec_bus == $past(i_cfg_wdata[15:8]))
        else $error("secondary bus number not written");

    // Stored bytes read back as they were before the read
    a_cls_read: assert property (
        s_rd(6'h03) |=> o_cfg_rdata[7:0] == $past(o_cache_line_size))
        else $error("cache line size read back wrong");

    // Timer value readable where software wrote it
    a_lat_read: assert property (
        s_rd(6'h03) |=> o_cfg_rdata[15:8] == $past(pri_lat))
        else $error("latency timer read back wrong");

    // All three bus numbers come back in one dword
    a_bus_read: assert property (
        s_rd(6'h06) |=> o_cfg_rdata[23:0] ==
        {$past(o_sub_bus), $past(o_sec_bus), $past(o_pri_bus)})
        else $error("bus numbers read back wrong");

    // Every write completes, whatever lane it lands on
    a_wr_ack: assert property (
        i_cfg_wr |=> o_cfg_ack)
        else $error("write not acknowledged");

    // Writes to the base address 0 dword leave storage alone
    a_ro_hold: assert property (
        i_cfg_wr && i_cfg_dw == 6'h04
        |=> $stable(o_cache_line_size) && $stable(o_pri_bus))
        else $error("read-only write changed storage");

    // Every type 1 cycle gets a decision one cycle later
    a_fwd_done: assert property (
        i_t1_valid |=> o_fwd_done)
        else $error("forwarding decision missing");
endmodule

// ===== verification/cfg_host_model.sv
// Host-side model issuing queued configuration reads and writes
`timescale 1ns/100ps
module cfg_host_model (
    input wire logic i_mclk,
    input wire logic i_rst,
    output logic o_cfg_wr,
    output logic o_cfg_rd,
    output logic [5:0] o_cfg_dw,
    output logic [3:0] o_cfg_be,
    output logic [31:0] o_cfg_wdata
);
    logic [42:0] req_q[$]; // Pending {write, dword, enables, data}
    logic [42:0] cur; // Request being issued

    // Queue a request; issued one per edge, back to back
    task automatic push(input logic wr, input logic [5:0] dw,
                        input logic [3:0] be, input logic [31:0] d);
        req_q.push_back({wr, dw, be, d});
    endtask

    // Issue requests after rising edges; idle lines flip so stale
    // values never look like a held request
    initial begin
        o_cfg_wr = 1'b0;
        o_cfg_rd = 1'b0;
        o_cfg_dw = 6'h00;
        o_cfg_be = 4'h0;
        o_cfg_wdata = 32'h0;
        forever begin
            @(posedge i_mclk);
            if (!i_rst && req_q.size() > 0) begin
                cur = req_q.pop_front();
                o_cfg_wr <= cur[42];
                o_cfg_rd <= ~cur[42];
                {o_cfg_dw, o_cfg_be, o_cfg_wdata} <= cur[41:0];
            end else begin
                o_cfg_wr <= 1'b0;
                o_cfg_rd <= 1'b0;
                o_cfg_dw <= ~o_cfg_dw;
                o_cfg_be <= ~o_cfg_be;
                o_cfg_wdata <= ~o_cfg_wdata;
            end
        end
    end
endmodule

// ===== verification/bridge_config_header_regs_tb.sv
// Self-checking bench for the bridge configuration header registers
`timescale 1ns/100ps
module bridge_config_header_regs_tb;
    import bridge_cfg_pkg::*;
    logic i_mclk = 1'b0; // 25 MHz clock
    logic i_rst = 1'b1; // Reset, held at start
    logic cfg_wr, cfg_rd, ack, lat_exp, fwd_done, subtr;
    logic [5:0] cfg_dw;
    logic [3:0] cfg_be;
    logic [31:0] cfg_wdata, rdata, r;
    logic frame_start = 1'b0, txn_active = 1'b0, t1_valid = 1'b0;
    logic [7:0] t1_bus = 8'h00, cache_out, pri, sec, sub;
    fwd_kind_t fwd_kind;
    int error_cnt = 0, num_checks = 0, cycles = 0;
    logic [31:0] seed = 32'h84858513; // Xorshift state
    logic [7:0] s_cls = 8'h00, s_lat = 8'h00; // Shadow registers
    logic [7:0] s_pri = 8'h00, s_sec = 8'h00, s_sub = 8'h00;
    logic s_dec = 1'b1; // Shadow decode bit, subtractive at reset
    logic [32:0] rd_q[$]; // Expected acks: {is read, data}
    fwd_kind_t fwd_q[$]; // Expected forwarding decisions
    logic [5:0] dws[8] = '{6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h15,
                           6'h07, 6'h3f}; // Mapped plus unmapped

    cfg_host_model cfg_host_model_i (.i_mclk(i_mclk), .i_rst(i_rst),
        .o_cfg_wr(cfg_wr), .o_cfg_rd(cfg_rd), .o_cfg_dw(cfg_dw),
        .o_cfg_be(cfg_be), .o_cfg_wdata(cfg_wdata));
    bridge_config_header_regs bridge_config_header_regs_i (
        .i_mclk(i_mclk), .i_rst(i_rst), .i_cfg_wr(cfg_wr),
        .i_cfg_rd(cfg_rd), .i_cfg_dw(cfg_dw), .i_cfg_be(cfg_be),
        .i_cfg_wdata(cfg_wdata), .o_cfg_rdata(rdata), .o_cfg_ack(ack),
        .i_frame_start(frame_start), .i_txn_active(txn_active),
        .o_lat_expired(lat_exp), .i_t1_valid(t1_valid),
        .i_t1_bus(t1_bus), .o_fwd_kind(fwd_kind),
        .o_fwd_done(fwd_done), .o_subtractive(subtr),
        .o_cache_line_size(cache_out), .o_pri_bus(pri),
        .o_sec_bus(sec), .o_sub_bus(sub));

    // Free-running clock, 40 ns period
    initial begin
        forever #20 i_mclk = ~i_mclk;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    // Dword contents as software should see them
    function automatic logic [31:0] exp_rd(input logic [5:0] dw);
        case (dw)
            6'h02: return {16'h0604, 7'h00, s_dec, 8'h00};
            6'h03: return {8'h00, 8'h01, s_lat, s_cls};
            6'h06: return {8'h00, s_sub, s_sec, s_pri};
            6'h15: return {7'h00, s_dec, 24'h0};
            default: return 32'h0; // Base addresses and unmapped
        endcase
    endfunction

    // Where a type 1 cycle should go
    function automatic fwd_kind_t exp_kind(input logic [7:0] bus);
        if (bus == s_sec) return FWD_TYPE0;
        if (bus > s_sec && bus <= s_sub) return FWD_TYPE1;
        return FWD_NONE;
    endfunction

    task automatic summarize();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk_val(input string name, input logic [31:0] e,
                           input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", name, e, g);
        end
    endtask

    task automatic chk_rd(input logic [31:0] e, input logic [31:0] g);
        chk_val("read data", e, g);
    endtask

    task automatic chk_fwd(input fwd_kind_t e, input fwd_kind_t g);
        chk_val("forward kind", {30'h0, e}, {30'h0, g});
    endtask

    // Queue an access; writes update the shadow in issue order
    task automatic cfg(input logic wr, input logic [5:0] dw,
                       input logic [3:0] be, input logic [31:0] d);
        if (wr && dw == 6'h03) begin
            if (be[0]) s_cls = d[7:0];
            if (be[1]) s_lat = d[15:8];
        end
        if (wr && dw == 6'h06) begin
            if (be[0]) s_pri = d[7:0];
            if (be[1]) s_sec = d[15:8];
            if (be[2]) s_sub = d[23:16];
        end
        if (wr && dw == 6'h15 && be[3]) s_dec = d[24];
        cfg_host_model_i.push(wr, dw, be, d);
        rd_q.push_back({~wr, wr ? 32'h0 : exp_rd(dw)});
    endtask

    // Wait, bounded, until every queued access was acknowledged
    task automatic drain();
        int n;
        n = 0;
        while (rd_q.size() > 0 && n < 300) begin
            @(posedge i_mclk);
            n++;
        end
        #1;
        chk_val("pending acks", 0, rd_q.size());
    endtask

    // Latency timer; pre gives an earlier start that must restart
    task automatic lat_test(input logic [7:0] lim, input logic pre);
        int n;
        cfg(1'b1, 6'h03, 4'h2, {16'h0, lim, 8'h00});
        drain();
        if (pre) begin
            @(posedge i_mclk) frame_start <= 1'b1;
            txn_active <= 1'b1;
            @(posedge i_mclk) frame_start <= 1'b0;
            repeat (2) @(posedge i_mclk);
        end
        @(posedge i_mclk) frame_start <= 1'b1;
        txn_active <= 1'b1;
        n = 0;
        do begin
            @(posedge i_mclk) frame_start <= 1'b0;
            #1 n++;
        end while (lat_exp !== 1'b1 && n < 300);
        chk_val("expiry cycles", lim + 2, n);
        @(posedge i_mclk) txn_active <= 1'b0;
        @(posedge i_mclk);
        #1 chk_val("expiry after end", 0, lat_exp);
    endtask

    // Type 1 cycle, held back to back by consecutive calls
    task automatic t1(input logic [7:0] bus);
        @(posedge i_mclk) t1_valid <= 1'b1;
        t1_bus <= bus;
        fwd_q.push_back(exp_kind(bus));
    endtask

    // Result watcher: oldest note against each ack or decision
    always @(negedge i_mclk) begin
        logic [32:0] e;
        if (ack === 1'b1) begin
            e = (rd_q.size() > 0) ? rd_q.pop_front() : {1'b1, ~rdata};
            if (e[32]) chk_rd(e[31:0], rdata);
        end
        if (fwd_done === 1'b1)
            chk_fwd(fwd_q.size() > 0 ? fwd_q.pop_front() : FWD_NONE,
                    fwd_kind);
    end

    // Hang guard, far beyond the couple of hundred cycles needed
    always @(posedge i_mclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            summarize();
        end
    end

    initial begin
        repeat (12) @(posedge i_mclk);
        i_rst <= 1'b0;
        @(posedge i_mclk);
        #1 chk_val("decode out", 1, subtr);
        chk_val("bus outs", 0, {cache_out, pri, sec, sub});
        foreach (dws[i]) cfg(1'b0, dws[i], 4'h1, 32'h0);
        drain();
        // Random back-to-back traffic, read-only lanes included
        repeat (60) begin
            r = rnd();
            cfg(r[31], dws[r[2:0]], r[6:3], rnd());
        end
        drain();
        chk_val("regs out", {s_cls, s_pri, s_sec, s_sub},
                {cache_out, pri, sec, sub});
        chk_val("decode out", s_dec, subtr);
        cfg(1'b1, 6'h15, 4'h8, 32'h0);
        cfg(1'b0, 6'h02, 4'hf, 32'h0);
        drain();
        chk_val("positive decode", 0, subtr);
        cfg(1'b1, 6'h15, 4'h8, 32'h0100_0000);
        cfg(1'b1, 6'h06, 4'h6, 32'h0009_0500);
        drain();
        foreach (dws[i]) t1(8'h03 + {5'h0, i[2:0]});
        t1(8'h0a);
        t1(8'hff);
        repeat (4) begin
            r = rnd();
            cfg(1'b1, 6'h06, 4'h7, r);
            @(posedge i_mclk) t1_valid <= 1'b0;
            t1_bus <= ~t1_bus;
            drain();
            repeat (8) begin
                r = rnd();
                t1(s_sec + {5'h0, r[2:0]} - 8'h02);
            end
        end
        @(posedge i_mclk) t1_valid <= 1'b0;
        t1_bus <= ~t1_bus;
        lat_test(8'h00, 1'b0);
        lat_test(8'h05, 1'b1);
        cfg(1'b1, 6'h03, 4'h2, 32'h0000_0a00);
        drain();
        @(posedge i_mclk) frame_start <= 1'b1;
        txn_active <= 1'b1;
        @(posedge i_mclk) frame_start <= 1'b0;
        repeat (3) @(posedge i_mclk);
        txn_active <= 1'b0;
        repeat (20) @(posedge i_mclk);
        #1 chk_val("idle expiry", 0, lat_exp);
        chk_val("pending decisions", 0, fwd_q.size());
        summarize();
    end
endmodule
